// File: common/fpec_pkg.sv
`default_nettype none

package fpec_pkg;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam int          REG_AW       = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_KEY      = 4'h1;
  localparam logic [3:0]  REG_PAGE     = 4'h2;
  localparam logic [3:0]  REG_OFFSET   = 4'h3;
  localparam logic [3:0]  REG_LATCH_LO = 4'h4;
  localparam logic [3:0]  REG_LATCH_HI = 4'h5;

  localparam logic [15:0] KEY_FIRST    = 16'h0055;
  localparam logic [15:0] KEY_SECOND   = 16'h00AA;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK   = 16'h707F; // software bits
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_ERASE_4ROW = 6'h1A;
  localparam logic [5:0] OPC_ERASE_2ROW = 6'h19;
  localparam logic [5:0] OPC_ERASE_1ROW = 6'h18;
  localparam logic [3:0] OPC_ERASE_CFG  = 4'h5;
  localparam logic [3:0] OPC_ERASE_EE   = 4'h4;
  localparam logic [3:0] OPC_ERASE_GEN  = 4'h3;
  localparam logic [3:0] OPC_ERASE_BOOT = 4'hA;
  localparam logic [3:0] OPC_ERASE_ALL  = 4'h9;
  localparam logic [3:0] OPC_WRITE_ROW  = 4'h1;

  // ----------------------------------------------------------------
  // row geometry and timing
  // ----------------------------------------------------------------
  localparam int          ROW_WORDS  = 32;
  localparam int          LATCH_AW   = 5;
  localparam logic [23:0] ROW_MASK_1 = 24'h00003F;
  localparam logic [23:0] ROW_MASK_2 = 24'h00007F;
  localparam logic [23:0] ROW_MASK_4 = 24'h0000FF;

  localparam int CLK_PERIOD_NS  = 4;
  localparam int ERASE_TIME_NS  = 2000;
  localparam int PROG_TIME_NS   = 2000;
  localparam int ERASE_CYCLES   =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES    =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       op_write_allow;
    logic       sequence_error_flag;
    logic       program_only_select;
    logic [4:0] rsvd;
    logic       erase;
    logic [5:0] operation_code;
  } fpec_ctrl_s;

  typedef enum logic [3:0] {
    FOP_NONE       = 4'h0,
    FOP_ERASE_ROW1 = 4'h1,
    FOP_ERASE_ROW2 = 4'h2,
    FOP_ERASE_ROW4 = 4'h3,
    FOP_ERASE_CFG  = 4'h4,
    FOP_ERASE_EE   = 4'h5,
    FOP_ERASE_GEN  = 4'h6,
    FOP_ERASE_BOOT = 4'h7,
    FOP_ERASE_ALL  = 4'h8,
    FOP_WRITE_WORD = 4'h9
  } fpec_fop_e;

  typedef struct packed {
    logic      valid;
    fpec_fop_e op;
    logic [23:0] addr;
    logic [23:0] data;
  } fpec_flash_req_s;

  // opcode plus erase select to flash operation
  function automatic fpec_fop_e fpec_decode(input logic       erase,
                                            input logic [5:0] opc);
    fpec_fop_e r;
    r = FOP_NONE;
    if (!erase) begin
      if (opc[5:2] == OPC_WRITE_ROW) r = FOP_WRITE_WORD;
    end else if (opc == OPC_ERASE_4ROW) begin
      r = FOP_ERASE_ROW4;
    end else if (opc == OPC_ERASE_2ROW) begin
      r = FOP_ERASE_ROW2;
    end else if (opc == OPC_ERASE_1ROW) begin
      r = FOP_ERASE_ROW1;
    end else if (opc[5:2] == OPC_ERASE_CFG) begin
      r = FOP_ERASE_CFG;
    end else if (opc[5:2] == OPC_ERASE_EE) begin
      r = FOP_ERASE_EE;
    end else if (opc[5:2] == OPC_ERASE_GEN) begin
      r = FOP_ERASE_GEN;
    end else if (opc[5:2] == OPC_ERASE_BOOT) begin
      r = FOP_ERASE_BOOT;
    end else if (opc[5:2] == OPC_ERASE_ALL) begin
      r = FOP_ERASE_ALL;
    end
    return r;
  endfunction

  // aligned base of the rows an operation touches
  function automatic logic [23:0] fpec_row_base(input logic [23:0] tp,
                                                input fpec_fop_e   op);
    logic [23:0] m;
    m = ROW_MASK_1;
    if (op == FOP_ERASE_ROW2) m = ROW_MASK_2;
    if (op == FOP_ERASE_ROW4) m = ROW_MASK_4;
    return tp & ~m;
  endfunction

endpackage

`default_nettype wire

// File: hw/fpec_latch_mem.sv
`default_nettype none

// ------------------------------------------------------------------
// holding latches: one row of words, split low word / high byte
// ------------------------------------------------------------------
module fpec_latch_mem
  import fpec_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int LO_W  = 16,
  parameter int HI_W  = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wr_lo,
  input  wire logic                 wr_hi,
  input  wire logic [AW-1:0]        waddr,
  input  wire logic [LO_W-1:0]      wdata_lo,
  input  wire logic [HI_W-1:0]      wdata_hi,
  input  wire logic [AW-1:0]        raddr,
  output logic      [HI_W+LO_W-1:0] rdata
);

  logic [LO_W-1:0] mem_lo [DEPTH];
  logic [HI_W-1:0] mem_hi [DEPTH];

  // latch writes, no reset on the array
  always_ff @(posedge clk) begin
    if (wr_lo) mem_lo[waddr] <= wdata_lo;
    if (wr_hi) mem_hi[waddr] <= wdata_hi;
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= '0;
    else        rdata <= {mem_hi[raddr], mem_lo[raddr]};
  end

endmodule

`default_nettype wire

// File: hw/fpec_top.sv
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none

// Operation
// RULE_01 - software writes 55h then AAh key
// RULE_02 - key register is write only
// RULE_03 - core stalled while operation runs
// RULE_04 - start bit launches, hardware clears when done
// RULE_05 - start bit set only, zero after reset
// RULE_06 - write enable allows or inhibits operations
// RULE_07 - error flag evaluated on every start attempt
// RULE_08 - program-only bit stored, no flash effect
// RULE_09 - bits eleven to seven read zero
// RULE_10 - erase bit picks erase or program variant
// RULE_11 - row erase codes: four, two, one
// RULE_12 - config, eeprom, general block erase codes
// RULE_13 - boot and full erase only serial mode
// RULE_14 - code 0001xx writes one row
// RULE_15 - undefined codes do nothing
// RULE_16 - rows chosen from page plus offset
// RULE_17 - a row is 32 instruction words
// RULE_18 - software row erase sequence
// RULE_19 - software row program sequence
// RULE_20 - software waits after start
// RULE_21 - control write window one cycle after key
// RULE_22 - table writes held in latches until start
// RULE_23 - bad start attempt sets error, no launch
// RULE_24 - wrong key resets unlock detector
module fpec_top
  import fpec_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PROG_CNT  = PROG_CYCLES,
  parameter int WORDS     = ROW_WORDS
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [REG_AW-1:0]  reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  input  wire logic               serial_prog_pin,
  output logic                    core_stall,
  output fpec_flash_req_s         flash_req
);

  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_GOT1  = 3'b010,
    KEY_OPEN  = 3'b100
  } fpec_key_e;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'b001,
    OP_ERASE = 3'b010,
    OP_PROG  = 3'b100
  } fpec_op_e;

  fpec_key_e        key_st;
  fpec_key_e        next_key_st;
  fpec_op_e         op_st;
  fpec_op_e         next_op_st;
  fpec_ctrl_s       ctrl;
  fpec_ctrl_s       next_ctrl;
  fpec_ctrl_s       wr_ctrl;
  fpec_fop_e        run_op;
  logic [7:0]       table_page_pointer;
  logic [15:0]      tbl_offset;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [LATCH_AW-1:0] idx;
  logic [LATCH_AW-1:0] rd_idx;
  logic             idx_run;
  logic             rd_pend;
  logic [23:0]      row_base;
  logic [23:0]      latch_rdata;
  logic             ser_meta;
  logic             self_programming_mode_n;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire busy     = (op_st != OP_IDLE);
  wire wr_ctrl_hit = reg_wr && reg_addr == REG_CTRL && !busy;
  wire wr_key   = reg_wr && reg_addr == REG_KEY;
  wire wr_page  = reg_wr && reg_addr == REG_PAGE && !busy;
  wire wr_off   = reg_wr && reg_addr == REG_OFFSET && !busy;
  wire wr_lat_lo = reg_wr && reg_addr == REG_LATCH_LO && !busy;
  wire wr_lat_hi = reg_wr && reg_addr == REG_LATCH_HI && !busy;
  wire key_is_1 = reg_wdata == KEY_FIRST;
  wire key_is_2 = reg_wdata == KEY_SECOND;

  // ----------------------------------------------------------------
  // serial programming mode pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_meta                <= 1'b0;
      self_programming_mode_n <= 1'b0;
    end else begin
      ser_meta                <= serial_prog_pin;
      self_programming_mode_n <= ser_meta;
    end
  end

  // ----------------------------------------------------------------
  // unlock detector
  // ----------------------------------------------------------------
  always_comb begin
    next_key_st = key_st;
    unique case (key_st)
      KEY_IDLE: begin
        if (wr_key && key_is_1) next_key_st = KEY_GOT1; // RULE_01
      end
      KEY_GOT1: begin
        if (wr_key) begin
          if (key_is_2)      next_key_st = KEY_OPEN; // RULE_01
          else if (key_is_1) next_key_st = KEY_GOT1;
          else               next_key_st = KEY_IDLE; // RULE_24
        end
      end
      KEY_OPEN: begin
        // window lasts exactly one cycle
        if (wr_key && key_is_1) next_key_st = KEY_GOT1; // RULE_21
        else                    next_key_st = KEY_IDLE; // RULE_21
      end
      default: next_key_st = KEY_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) key_st <= KEY_IDLE;
    else        key_st <= next_key_st;
  end

  // ----------------------------------------------------------------
  // start attempt evaluation
  // ----------------------------------------------------------------
  assign wr_ctrl = fpec_ctrl_s'(reg_wdata & CTRL_WMASK); // RULE_09

  wire       window   = key_st == KEY_OPEN; // RULE_21
  wire       try_start = wr_ctrl_hit && reg_wdata[15]; // RULE_07
  fpec_fop_e req_op;
  assign req_op = fpec_decode(wr_ctrl.erase, // RULE_10
                              wr_ctrl.operation_code);
  wire       ser_only = req_op == FOP_ERASE_BOOT ||
                        req_op == FOP_ERASE_ALL;
  wire       mode_bad = ser_only && !self_programming_mode_n; // RULE_13
  wire       seq_bad  = !window || !wr_ctrl.op_write_allow || // RULE_23
                        mode_bad; // RULE_06
  wire       launch   = try_start && !seq_bad &&
                        req_op != FOP_NONE; // RULE_15
  wire       op_done  = busy && cnt == '0 && !idx_run && !rd_pend;

  // ----------------------------------------------------------------
  // control register next value
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl_hit) begin
      next_ctrl.op_write_allow = wr_ctrl.op_write_allow; // RULE_06
      next_ctrl.sequence_error_flag = wr_ctrl.sequence_error_flag;
      next_ctrl.program_only_select = wr_ctrl.program_only_select; // RULE_08
      next_ctrl.erase = wr_ctrl.erase;
      next_ctrl.operation_code = wr_ctrl.operation_code;
    end
    // the hardware verdict wins over the written flag
    if (try_start) next_ctrl.sequence_error_flag = seq_bad; // RULE_07 RULE_23
    if (launch)    next_ctrl.wr   = 1'b1; // RULE_04 RULE_05
    if (op_done)   next_ctrl.wr   = 1'b0; // RULE_04
    next_ctrl.rsvd = '0; // RULE_09
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl <= fpec_ctrl_s'(CTRL_RESET); // RULE_05
    else        ctrl <= next_ctrl;
  end

  // ----------------------------------------------------------------
  // table pointer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_page_pointer <= PAGE_RESET;
      tbl_offset         <= ZERO16;
    end else begin
      if (wr_page) table_page_pointer <= reg_wdata[7:0];
      if (wr_off)  tbl_offset         <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // holding latches
  // ----------------------------------------------------------------
  fpec_latch_mem #(
    .DEPTH (WORDS),
    .AW    (LATCH_AW),
    .LO_W  (16),
    .HI_W  (8)
  ) u_latch (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_lo    (wr_lat_lo), // RULE_22
    .wr_hi    (wr_lat_hi), // RULE_22
    .waddr    (tbl_offset[LATCH_AW:1]),
    .wdata_lo (reg_wdata),
    .wdata_hi (reg_wdata[7:0]),
    .raddr    (idx),
    .rdata    (latch_rdata)
  );

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  wire [23:0] tptr = {table_page_pointer, tbl_offset}; // RULE_16

  always_comb begin
    next_op_st = op_st;
    next_cnt   = cnt;
    unique case (op_st)
      OP_IDLE: begin
        if (launch && req_op == FOP_WRITE_WORD) begin
          next_op_st = OP_PROG;
          next_cnt   = CNT_W'(PROG_CNT - 1);
        end else if (launch) begin
          next_op_st = OP_ERASE;
          next_cnt   = CNT_W'(ERASE_CNT - 1);
        end
      end
      OP_ERASE, OP_PROG: begin
        if (cnt != '0)   next_cnt   = cnt - 1'b1;
        else if (op_done) next_op_st = OP_IDLE; // RULE_03
      end
      default: next_op_st = OP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_st <= OP_IDLE;
      cnt   <= '0;
    end else begin
      op_st <= next_op_st;
      cnt   <= next_cnt;
    end
  end

  // latched operation and target rows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_op   <= FOP_NONE;
      row_base <= '0;
    end else if (launch) begin
      run_op   <= req_op; // RULE_11 RULE_12 RULE_13 RULE_14
      row_base <= fpec_row_base(tptr, req_op); // RULE_16 RULE_17
    end
  end

  // latch streaming index, one word per cycle
  wire last_idx = idx == LATCH_AW'(WORDS - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx     <= '0;
      idx_run <= 1'b0;
      rd_pend <= 1'b0;
      rd_idx  <= '0;
    end else begin
      rd_pend <= idx_run;
      rd_idx  <= idx;
      if (launch && req_op == FOP_WRITE_WORD) begin
        idx     <= '0;
        idx_run <= 1'b1; // RULE_22
      end else if (idx_run) begin
        idx     <= idx + 1'b1;
        idx_run <= !last_idx; // RULE_17
      end
    end
  end

  // ----------------------------------------------------------------
  // flash command output
  // ----------------------------------------------------------------
  wire erase_go = op_st == OP_ERASE && cnt == CNT_W'(ERASE_CNT - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_req <= '0;
    end else if (rd_pend) begin
      flash_req.valid <= 1'b1;
      flash_req.op    <= FOP_WRITE_WORD; // RULE_14
      flash_req.addr  <= row_base + {18'h0, rd_idx, 1'b0};
      flash_req.data  <= latch_rdata; // RULE_22
    end else if (erase_go) begin
      flash_req.valid <= 1'b1;
      flash_req.op    <= run_op; // RULE_11 RULE_12
      flash_req.addr  <= row_base;
      flash_req.data  <= '0;
    end else begin
      flash_req <= '0;
    end
  end

  // ----------------------------------------------------------------
  // stall and read data
  // ----------------------------------------------------------------
  assign core_stall = busy; // RULE_03

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = ZERO16;
    unique case (reg_addr)
      REG_CTRL:   rd_mux = ctrl; // RULE_09
      REG_PAGE:   rd_mux = {8'h00, table_page_pointer};
      REG_OFFSET: rd_mux = tbl_offset;
      default:    rd_mux = ZERO16; // RULE_02
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)      reg_rdata <= ZERO16;
    else if (reg_rd) reg_rdata <= rd_mux;
    else             reg_rdata <= ZERO16;
  end

endmodule

`default_nettype wire

// File: testbench/fpec_top_chk.sv
`default_nettype none

// ----------------------------------------------------------------
// port checker for the flash sequencer
// ----------------------------------------------------------------
module fpec_top_chk
  import fpec_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PROG_CNT  = PROG_CYCLES,
  parameter int WORDS     = ROW_WORDS
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              serial_prog_pin,
  input wire logic              core_stall,
  input wire fpec_flash_req_s   flash_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [CNT_W-1:0] stall_cnt;
  wire              ctrl_rd = reg_rd && (reg_addr == REG_CTRL);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // cycles spent in the current stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) stall_cnt <= '0;
    else stall_cnt <= core_stall ? stall_cnt + 1'b1 : '0;
  end

  // start attempt with write enable low, and a stall beginning
  sequence s_inhibited;
    reg_wr && reg_addr == REG_CTRL && reg_wdata[15:14] == 2'h2
      && !core_stall;
  endsequence
  sequence s_launch;
    !core_stall ##1 core_stall;
  endsequence

  AST_KEY_HIDDEN: assert property (reg_rd && reg_addr == REG_KEY |=>
    reg_rdata == ZERO16) else $error("key register read not zero");
  AST_RSVD_ZERO: assert property (ctrl_rd |=> reg_rdata[11:7] == 5'h00)
    else $error("unimplemented control bits read nonzero");
  AST_START_MIRROR: assert property (ctrl_rd |=>
    reg_rdata[15] == $past(core_stall)) else $error("start bit wrong");
  AST_STALL_CAUSE: assert property ($rose(core_stall) |->
    $past(reg_wr && reg_addr == REG_CTRL && reg_wdata[15]))
    else $error("stall without start write");
  AST_STALL_LEN: assert property ($fell(core_stall) |->
    stall_cnt == CNT_W'(ERASE_CNT) || stall_cnt == CNT_W'(PROG_CNT))
    else $error("stall length wrong");
  AST_REQ_IN_STALL: assert property (flash_req.valid |-> core_stall)
    else $error("flash request outside operation");
  AST_REQ_FOLLOWS: assert property (s_launch |-> ##[1:2] flash_req.valid)
    else $error("no flash request after start");
  AST_INHIBIT: assert property (s_inhibited |=>
    !core_stall ##1 !core_stall) else $error("inhibited start ran");
  AST_DEFINED_OP: assert property (flash_req.valid |->
    flash_req.op != FOP_NONE) else $error("request with no operation");
  AST_WORD_STEP: assert property (flash_req.valid &&
    flash_req.op == FOP_WRITE_WORD && $past(flash_req.valid) |->
    flash_req.addr == $past(flash_req.addr) + 24'h000002)
    else $error("word address step wrong");
  AST_ROW4_ALIGN: assert property (flash_req.valid &&
    flash_req.op == FOP_ERASE_ROW4 |-> flash_req.addr[7:0] == 8'h00)
    else $error("four row erase not aligned");
endmodule

bind fpec_top fpec_top_chk #(
  .ERASE_CNT (ERASE_CNT),
  .PROG_CNT  (PROG_CNT),
  .WORDS     (WORDS)
) u_fpec_top_chk (
  .clk             (clk),
  .rst_n           (rst_n),
  .reg_addr        (reg_addr),
  .reg_wdata       (reg_wdata),
  .reg_wr          (reg_wr),
  .reg_rd          (reg_rd),
  .reg_rdata       (reg_rdata),
  .serial_prog_pin (serial_prog_pin),
  .core_stall      (core_stall),
  .flash_req       (flash_req)
);

`default_nettype wire

// File: testbench/fpec_core.sv
`default_nettype none

// ----------------------------------------------------------------
// core software model driving the register port
// ----------------------------------------------------------------
module fpec_core
  import fpec_pkg::*;
(
  input  wire logic              clk,
  output logic      [REG_AW-1:0] reg_addr,
  output logic      [15:0]       reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [15:0]       reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // write strobe for one cycle, left for the next call to replace
  task automatic wr_reg(input logic [REG_AW-1:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clk);
  endtask

  // read strobe, data taken in the cycle after
  task automatic rd_reg(input logic [REG_AW-1:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask

  // strobes low for n cycles
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // key pair, optionally broken by a stray key value
  task automatic unlock(input logic bad);
    wr_reg(REG_KEY, KEY_FIRST);
    if (bad) wr_reg(REG_KEY, 16'h0011);
    wr_reg(REG_KEY, KEY_SECOND);
  endtask
endmodule

`default_nettype wire

// File: testbench/fpec_top_tb.sv
`default_nettype none

// ----------------------------------------------------------------
// flash sequencer testbench
// ----------------------------------------------------------------
module fpec_top_tb
  import fpec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCYC = 40;

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              serial_prog_pin = 1'b0;
  logic [REG_AW-1:0] reg_addr;
  logic [15:0]       reg_wdata, reg_rdata, rd;
  logic              reg_wr, reg_rd, core_stall;
  fpec_flash_req_s   flash_req;
  fpec_fop_e         f_op;
  logic [23:0]       tp;
  int                bad_count = 0, checks = 0, n_req = 0, stall_n = 0;

  fpec_top #(
    .ERASE_CNT (NCYC),
    .PROG_CNT  (NCYC),
    .WORDS     (ROW_WORDS)
  ) u_fpec_top (
    .clk             (clk),
    .rst_n           (rst_n),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .serial_prog_pin (serial_prog_pin),
    .core_stall      (core_stall),
    .flash_req       (flash_req)
  );

  fpec_core u_fpec_core (
    .clk       (clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // 4 ns clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [23:0] row_mask(input fpec_fop_e op);
    if (op == FOP_ERASE_ROW4) return ROW_MASK_4;
    if (op == FOP_ERASE_ROW2) return ROW_MASK_2;
    return ROW_MASK_1;
  endfunction

  // watch flash requests and stall length
  always @(posedge clk) begin
    if (core_stall) stall_n++;
    if (flash_req.valid) begin
      if (n_req == 0) f_op = flash_req.op;
      chk(flash_req.addr,
          (tp & ~row_mask(flash_req.op)) + 24'(2 * n_req));
      if (flash_req.op == FOP_WRITE_WORD)
        chk(flash_req.data, {8'h40 + 8'(n_req), 16'hA500 + 16'(n_req)});
      n_req++;
    end
  end

  // set up, unlock, start, then compare the outcome
  task automatic run(input logic e, input logic [5:0] opc,
                     input logic en, gap, bad, go, werr,
                     input fpec_fop_e op, input int np);
    logic [15:0] setup;
    setup = {1'b0, en, 7'h00, e, opc};
    n_req = 0;
    stall_n = 0;
    u_fpec_core.wr_reg(REG_CTRL, setup);
    u_fpec_core.unlock(bad);
    if (gap) u_fpec_core.idle(1);
    u_fpec_core.wr_reg(REG_CTRL, setup | 16'h8000);
    if (go) begin
      u_fpec_core.wr_reg(REG_CTRL, ZERO16);
      u_fpec_core.rd_reg(REG_CTRL, rd);
      chk(24'(rd), 24'(setup | 16'h8000));
    end
    u_fpec_core.idle(60);
    chk(24'(stall_n), go ? 24'(NCYC) : 24'h000000);
    chk(24'(n_req), 24'(np));
    if (go) chk(24'(f_op), 24'(op));
    u_fpec_core.rd_reg(REG_CTRL, rd);
    chk(24'(rd), 24'(setup | {2'h0, werr, 13'h0000}));
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    u_fpec_core.rd_reg(REG_CTRL, rd);
    chk(24'(rd), 24'(CTRL_RESET));
    u_fpec_core.wr_reg(REG_KEY, KEY_FIRST);
    u_fpec_core.rd_reg(REG_KEY, rd);
    chk(24'(rd), 24'h000000);
    u_fpec_core.rd_reg(4'hF, rd);
    chk(24'(rd), 24'h000000);
    u_fpec_core.wr_reg(REG_CTRL, 16'h1FD8);
    u_fpec_core.rd_reg(REG_CTRL, rd);
    chk(24'(rd), 24'h001058);
    u_fpec_core.wr_reg(REG_PAGE, 16'h0001);
    u_fpec_core.wr_reg(REG_OFFSET, 16'h0150);
    tp = 24'h010150;
    run(1, 6'h18, 0, 0, 0, 0, 1, FOP_NONE, 0);
    run(1, 6'h18, 1, 1, 0, 0, 1, FOP_NONE, 0);
    run(1, 6'h18, 1, 0, 1, 0, 1, FOP_NONE, 0);
    run(1, 6'h1A, 1, 0, 0, 1, 0, FOP_ERASE_ROW4, 1);
    run(1, 6'h19, 1, 0, 0, 1, 0, FOP_ERASE_ROW2, 1);
    run(1, 6'h18, 1, 0, 0, 1, 0, FOP_ERASE_ROW1, 1);
    run(1, 6'h17, 1, 0, 0, 1, 0, FOP_ERASE_CFG, 1);
    run(1, 6'h11, 1, 0, 0, 1, 0, FOP_ERASE_EE, 1);
    run(1, 6'h0E, 1, 0, 0, 1, 0, FOP_ERASE_GEN, 1);
    run(1, 6'h28, 1, 0, 0, 0, 1, FOP_NONE, 0);
    run(1, 6'h24, 1, 0, 0, 0, 1, FOP_NONE, 0);
    run(1, 6'h3F, 1, 0, 0, 0, 0, FOP_NONE, 0);
    run(1, 6'h05, 1, 0, 0, 0, 0, FOP_NONE, 0);
    run(0, 6'h18, 1, 0, 0, 0, 0, FOP_NONE, 0);
    for (int i = 0; i < ROW_WORDS; i++) begin
      u_fpec_core.wr_reg(REG_OFFSET, 16'(2 * i));
      u_fpec_core.wr_reg(REG_LATCH_LO, 16'hA500 + 16'(i));
      u_fpec_core.wr_reg(REG_LATCH_HI, 16'h0040 + 16'(i));
    end
    tp = 24'h01003E;
    run(0, 6'h07, 1, 0, 0, 1, 0, FOP_WRITE_WORD, ROW_WORDS);
    serial_prog_pin <= 1'b1;
    u_fpec_core.idle(3);
    run(1, 6'h28, 1, 0, 0, 1, 0, FOP_ERASE_BOOT, 1);
    run(1, 6'h24, 1, 0, 0, 1, 0, FOP_ERASE_ALL, 1);
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
